// ==== rtl/deep_sync_fifo.sv ====
// Deep synchronous FIFO port: pin sampling, flags, cascade and storage FIFO
`timescale 1ns/100ps
`default_nettype none

// Storage FIFO with valid/ready on both sides and a rewind input
module sync_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    input wire logic rewind,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [LW-1:0] level;
    } fifo_state_t;

    fifo_state_t st_r;
    fifo_state_t st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic doPush;
    logic doPop;

    assign inReady = (st_r.level != LW'(DEPTH));
    assign outValid = (st_r.level != '0);
    assign outData = mem[st_r.rdPtr];
    assign level = st_r.level;
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;

    always_comb begin
        st_nxt = st_r;
        if (doPush) begin
            st_nxt.wrPtr = st_r.wrPtr + 1'b1;
        end
        if (rewind) begin
            // Replays from the first word; exact while fewer than DEPTH writes
            st_nxt.rdPtr = '0;
            st_nxt.level = LW'(st_nxt.wrPtr);
        end else begin
            if (doPop) begin
                st_nxt.rdPtr = st_r.rdPtr + 1'b1;
            end
            st_nxt.level = LW'(st_r.level + LW'(doPush) - LW'(doPop));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[st_r.wrPtr] <= inData;
        end
    end
endmodule

module deep_sync_fifo #(
    parameter int DEPTH = deep_fifo_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [deep_fifo_pkg::DATA_W-1:0] dataIn,
    input wire logic writeClk,
    input wire logic readClk,
    input wire logic writeEnableN,
    input wire logic readEnableN,
    input wire logic offsetLoadN,
    input wire logic firstLoadRetransmit,
    input wire logic writeCascadeIn,
    input wire logic readCascadeIn,
    input wire logic outputEnableN,
    input wire logic flagSyncSelect,
    input wire logic cascadeMode,
    output logic [deep_fifo_pkg::DATA_W-1:0] dataOut,
    output logic dataOutEn,
    output logic emptyFlagN,
    output logic fullFlagN,
    output logic almostEmptyFlagN,
    output logic almostFullFlagN,
    output logic writeCascadeOutHalfFull,
    output logic readCascadeOut
);
    localparam int DW = deep_fifo_pkg::DATA_W;
    localparam int PW = deep_fifo_pkg::PIN_W;
    localparam int LW = $clog2(DEPTH+1);

    typedef logic [DW:0] wide_t;

    typedef struct packed {
        logic [PW-1:0] s1;
        logic [PW-1:0] s2;
        logic [PW-1:0] s3;
        logic [PW-1:0] acc;
        logic [PW-1:0] accD;
        logic [1:0] armCnt;
        logic armed;
        logic wTok;
        logic rTok;
        logic [DW-1:0] offset;
        logic [DW-1:0] dataOut;
        logic dataOutEn;
        logic emptyN;
        logic fullN;
        logic aeN;
        logic afN;
        logic wxoHf;
        logic read_cascade_out;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;
    logic [PW-1:0] pins;
    logic wrEdge;
    logic rdEdge;
    logic loadLow;
    logic casc;
    logic push;
    logic pop;
    logic rewind;
    logic fifoInReady;
    logic fifoOutValid;
    logic [DW-1:0] fifoHead;
    logic [LW-1:0] level;
    logic [LW-1:0] lvlNext;
    logic aeHit;
    logic afHit;

    function automatic logic rose(input logic [PW-1:0] now, input logic [PW-1:0] was,
                                  input int idx);
        rose = now[idx] && !was[idx];
    endfunction

    assign pins = {cascadeMode, flagSyncSelect, outputEnableN, readCascadeIn,
                   writeCascadeIn, firstLoadRetransmit, offsetLoadN, readEnableN,
                   writeEnableN, readClk, writeClk, dataIn};

    assign wrEdge = st_r.armed && rose(st_r.acc, st_r.accD, deep_fifo_pkg::PIN_WCLK);
    assign rdEdge = st_r.armed && rose(st_r.acc, st_r.accD, deep_fifo_pkg::PIN_RCLK);
    assign loadLow = !st_r.acc[deep_fifo_pkg::PIN_LD_N];
    assign casc = st_r.acc[deep_fifo_pkg::PIN_CASC];
    // Full write or empty read is refused by the FIFO handshake
    assign push = wrEdge && !loadLow && !st_r.acc[deep_fifo_pkg::PIN_WEN_N]
                  && (!casc || st_r.wTok);
    assign pop = rdEdge && !loadLow && !st_r.acc[deep_fifo_pkg::PIN_REN_N]
                 && (!casc || st_r.rTok);
    assign rewind = st_r.armed && !casc
                    && rose(st_r.acc, st_r.accD, deep_fifo_pkg::PIN_FIRST_LOAD_RETRANSMIT);
    assign lvlNext = LW'(level + LW'(push && fifoInReady) - LW'(pop && fifoOutValid));
    assign aeHit = wide_t'(lvlNext) <= wide_t'(st_r.offset);
    assign afHit = wide_t'(lvlNext) + wide_t'(st_r.offset) >= wide_t'(DEPTH);

    sync_fifo #(
        .WIDTH(DW),
        .DEPTH(DEPTH)
    ) u_store (
        .clk(mclk),
        .rst(sys_rst),
        .inValid(push),
        .inReady(fifoInReady),
        .inData(st_r.acc[DW-1:0]),
        .outValid(fifoOutValid),
        .outReady(pop),
        .outData(fifoHead),
        .rewind(rewind),
        .level(level)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // A change is accepted once the second and third stages agree
        st_nxt.acc = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.acc);
        st_nxt.accD = st_r.acc;
        st_nxt.wxoHf = 1'b0;
        st_nxt.read_cascade_out = 1'b0;
        if (!st_r.armed) begin
            st_nxt.armCnt = st_r.armCnt + 1'b1;
            st_nxt.armed = (st_r.armCnt == deep_fifo_pkg::ARM_CYCLES);
            // No edge on the first armed cycle, whatever level a pin rests at
            st_nxt.accD = st_nxt.acc;
            // First device in a chain starts holding both tokens
            st_nxt.wTok = !st_nxt.acc[deep_fifo_pkg::PIN_FIRST_LOAD_RETRANSMIT];
            st_nxt.rTok = !st_nxt.acc[deep_fifo_pkg::PIN_FIRST_LOAD_RETRANSMIT];
            st_nxt.wxoHf = !casc;
        end else begin
            if (wrEdge && loadLow) begin
                st_nxt.offset = st_r.acc[DW-1:0];
            end
            if (rdEdge && loadLow) begin
                st_nxt.dataOut = st_r.offset;
            end else if (pop && fifoOutValid) begin
                st_nxt.dataOut = fifoHead;
            end
            if (rdEdge) begin
                st_nxt.emptyN = (lvlNext != '0);
            end
            if (wrEdge) begin
                st_nxt.fullN = (lvlNext != LW'(DEPTH));
            end
            if (st_r.acc[deep_fifo_pkg::PIN_SMODE] || rdEdge) begin
                st_nxt.aeN = !aeHit;
            end
            if (st_r.acc[deep_fifo_pkg::PIN_SMODE] || wrEdge) begin
                st_nxt.afN = !afHit;
            end
            if (casc) begin
                // Token passes on when this device fills or drains
                if (push && fifoInReady && lvlNext == LW'(DEPTH)) begin
                    st_nxt.wTok = 1'b0;
                    st_nxt.wxoHf = 1'b1;
                end else if (rose(st_r.acc, st_r.accD, deep_fifo_pkg::PIN_WXI)) begin
                    st_nxt.wTok = 1'b1;
                end
                if (pop && fifoOutValid && lvlNext == '0) begin
                    st_nxt.rTok = 1'b0;
                    st_nxt.read_cascade_out = 1'b1;
                end else if (rose(st_r.acc, st_r.accD, deep_fifo_pkg::PIN_RXI)) begin
                    st_nxt.rTok = 1'b1;
                end
            end else begin
                st_nxt.wxoHf = !(lvlNext > LW'(DEPTH / 2));
            end
        end
        st_nxt.dataOutEn = !st_r.acc[deep_fifo_pkg::PIN_OE_N];
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            // Back to the empty condition
            st_r <= '0;
            st_r.emptyN <= deep_fifo_pkg::RST_EMPTY_N;
            st_r.fullN <= deep_fifo_pkg::RST_FULL_N;
            st_r.aeN <= deep_fifo_pkg::RST_AE_N;
            st_r.afN <= deep_fifo_pkg::RST_AF_N;
            st_r.wxoHf <= deep_fifo_pkg::RST_HF;
            st_r.offset <= deep_fifo_pkg::RST_OFFSET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dataOut = st_r.dataOut;
    assign dataOutEn = st_r.dataOutEn;
    assign emptyFlagN = st_r.emptyN;
    assign fullFlagN = st_r.fullN;
    assign almostEmptyFlagN = st_r.aeN;
    assign almostFullFlagN = st_r.afN;
    assign writeCascadeOutHalfFull = st_r.wxoHf;
    assign readCascadeOut = st_r.read_cascade_out;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    AST_WRITE_STORES: assert property (
        push && fifoInReady && !(pop && fifoOutValid) && !rewind
        |=> level == $past(level) + 1'b1)
        else $error("accepted write did not raise the level");
    AST_READ_PRESENTS: assert property (
        pop && fifoOutValid |=> dataOut == $past(fifoHead))
        else $error("read did not present the head word");
    AST_OFFSET_LOAD: assert property (
        wrEdge && loadLow |=> st_r.offset == $past(st_r.acc[DW-1:0]) && level == $past(level)
            || $past(pop))
        else $error("offset load did not capture the input bus");
    AST_OFFSET_READ: assert property (
        rdEdge && loadLow |=> dataOut == $past(st_r.offset))
        else $error("offset read did not reach the output bus");
    AST_EMPTY_FLAG: assert property (
        rdEdge |=> emptyFlagN == (level != '0))
        else $error("empty flag disagrees with level after read edge");
    AST_FULL_FLAG: assert property (
        wrEdge |=> fullFlagN == (level != LW'(DEPTH)))
        else $error("full flag disagrees with level after write edge");
    AST_EMPTY_HOLDS: assert property (
        st_r.armed && !rdEdge |=> $stable(emptyFlagN))
        else $error("empty flag moved without a read edge");
    AST_FULL_HOLDS: assert property (
        st_r.armed && !wrEdge |=> $stable(fullFlagN))
        else $error("full flag moved without a write edge");
    AST_AE_ASYNC: assert property (
        st_r.armed && st_r.acc[deep_fifo_pkg::PIN_SMODE] |=> almostEmptyFlagN == $past(!aeHit))
        else $error("asynchronous almost-empty flag wrong");
    AST_AF_SYNC_HOLD: assert property (
        st_r.armed && !st_r.acc[deep_fifo_pkg::PIN_SMODE] && !wrEdge |=> $stable(almostFullFlagN))
        else $error("synchronous almost-full flag moved off a write edge");
    AST_REFUSED_WRITE: assert property (
        !fifoInReady && !pop && !rewind |=> level == $past(level))
        else $error("write into a full buffer changed the level");
    AST_OE_FOLLOWS: assert property (
        $fell(st_r.acc[deep_fifo_pkg::PIN_OE_N]) |=> dataOutEn ##1 1'b1)
        else $error("outputs not enabled after enable went low");
    AST_RXO_PULSE: assert property (
        readCascadeOut |=> !readCascadeOut && !st_r.rTok)
        else $error("read expansion output not a single pulse");
endmodule
`default_nettype wire

// ==== pkg/deep_fifo_pkg.sv ====
// Constants shared by the deep synchronous FIFO port
`default_nettype none
package deep_fifo_pkg;
    localparam int DATA_W = 18;
    localparam int FIFO_DEPTH = 16;
    // Bit positions inside the sampled pin vector
    localparam int PIN_DATA_LSB = 0;
    localparam int PIN_WCLK = 18;
    localparam int PIN_RCLK = 19;
    localparam int PIN_WEN_N = 20;
    localparam int PIN_REN_N = 21;
    localparam int PIN_LD_N = 22;
    localparam int PIN_FIRST_LOAD_RETRANSMIT = 23;
    localparam int PIN_WXI = 24;
    localparam int PIN_RXI = 25;
    localparam int PIN_OE_N = 26;
    localparam int PIN_SMODE = 27;
    localparam int PIN_CASC = 28;
    localparam int PIN_W = 29;
    // Last arming count; pins are trusted four cycles after reset release
    localparam logic [1:0] ARM_CYCLES = 2'h3;
    // Reset values of the outputs and of the offset register
    localparam logic RST_EMPTY_N = 1'b0;
    localparam logic RST_FULL_N = 1'b1;
    localparam logic RST_AE_N = 1'b0;
    localparam logic RST_AF_N = 1'b1;
    localparam logic RST_HF = 1'b1;
    localparam logic [DATA_W-1:0] RST_OFFSET = 18'h00000;
endpackage
`default_nettype wire

// ==== verif/fifo_pin_partner.sv ====
// Far-side pin model: write and read clock strobes for the FIFO port
`timescale 1ns/100ps
`default_nettype none
module fifo_pin_partner (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wrGo,
    input wire logic rdGo,
    output logic writeClk,
    output logic readClk
);
    logic [3:0] wCnt_r;
    logic [3:0] rCnt_r;
    // No strobe until reset has been applied
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wCnt_r <= 4'h0;
            rCnt_r <= 4'h0;
        end else begin
            wCnt_r <= (wrGo && wCnt_r == 4'h0) ? 4'hC : wCnt_r - 4'(wCnt_r != 4'h0);
            rCnt_r <= (rdGo && rCnt_r == 4'h0) ? 4'hC : rCnt_r - 4'(rCnt_r != 4'h0);
        end
    end
    // Six cycles high, six low, idle low between strobes
    assign writeClk = (wCnt_r > 4'h6);
    assign readClk = (rCnt_r > 4'h6);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the deep synchronous FIFO port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int DEPTH = 16;
    localparam logic [17:0] OFF = 18'h00004;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic [17:0] dataIn = 18'h00000;
    logic writeEnableN = 1'b1;
    logic readEnableN = 1'b1;
    logic offsetLoadN = 1'b1;
    logic firstLoadRetransmit = 1'b0;
    logic outputEnableN = 1'b0;
    logic flagSyncSelect = 1'b0;
    logic wrGo = 1'b0;
    logic rdGo = 1'b0;
    logic cascadeMode = 1'b0;
    logic writeCascadeIn = 1'b0;
    logic writeClk, readClk, dataOutEn, emptyFlagN, fullFlagN;
    logic almostEmptyFlagN, almostFullFlagN, halfFull, readCascadeOut;
    logic [17:0] dataOut;
    int errCount = 0;
    int nTests = 0;
    int cycles = 0;
    int wxoCnt = 0;
    int rxoCnt = 0;

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // Read cascade input tied low; first-load low, so this device leads a chain
    deep_sync_fifo #(.DEPTH(DEPTH)) deep_sync_fifo_inst (
        .mclk(mclk), .sys_rst(sysRst), .dataIn(dataIn), .writeClk(writeClk),
        .readClk(readClk), .writeEnableN(writeEnableN), .readEnableN(readEnableN),
        .offsetLoadN(offsetLoadN), .firstLoadRetransmit(firstLoadRetransmit),
        .writeCascadeIn(writeCascadeIn), .readCascadeIn(1'b0),
        .outputEnableN(outputEnableN), .flagSyncSelect(flagSyncSelect),
        .cascadeMode(cascadeMode), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN), .almostEmptyFlagN(almostEmptyFlagN),
        .almostFullFlagN(almostFullFlagN), .writeCascadeOutHalfFull(halfFull),
        .readCascadeOut(readCascadeOut)
    );

    fifo_pin_partner fifo_pin_partner_inst (
        .mclk(mclk), .sys_rst(sysRst), .wrGo(wrGo), .rdGo(rdGo),
        .writeClk(writeClk), .readClk(readClk)
    );

    task automatic reportAndStop();
        $display("Comparisons %0d, mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        // Cascade pulses, counted on the edge after they stand
        if (cascadeMode && halfFull) wxoCnt++;
        if (readCascadeOut) rxoCnt++;
        if (cycles == 5000) begin
            errCount++;
            reportAndStop();
        end
    end

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [17:0] pat(input int i);
        return 18'h155AA ^ (18'(i) * 18'h01234);
    endfunction

    task automatic doReset();
        sysRst <= 1'b1;
        repeat (4) @(posedge mclk);
        sysRst <= 1'b0;
        repeat (10) @(posedge mclk);
    endtask

    // One pin clock strobe with data and enables held well around it
    task automatic pinOp(input logic isWr, input logic enN, input logic ldN, input logic [17:0] w);
        @(posedge mclk);
        dataIn <= w;
        offsetLoadN <= ldN;
        if (isWr) writeEnableN <= enN;
        else readEnableN <= enN;
        repeat (6) @(posedge mclk);
        if (isWr) wrGo <= 1'b1;
        else rdGo <= 1'b1;
        @(posedge mclk);
        wrGo <= 1'b0;
        rdGo <= 1'b0;
        repeat (16) @(posedge mclk);
        dataIn <= ~w;
        offsetLoadN <= 1'b1;
        writeEnableN <= 1'b1;
        readEnableN <= 1'b1;
        @(posedge mclk);
    endtask

    task automatic testResetState();
        logic [4:0] flags;
        flags = {emptyFlagN, fullFlagN, almostEmptyFlagN, almostFullFlagN, halfFull};
        check(18'(flags), 18'h0000B);
    endtask

    task automatic testOffset();
        pinOp(1'b1, 1'b1, 1'b0, OFF);
        pinOp(1'b0, 1'b1, 1'b0, 18'h00000);
        check(dataOut, OFF);
    endtask

    task automatic testFill();
        for (int i = 0; i < DEPTH; i++) begin
            pinOp(1'b1, 1'b0, 1'b1, pat(i));
            check(18'(fullFlagN), 18'(i + 1 < DEPTH));
            check(18'(almostFullFlagN), 18'(i + 1 + OFF < DEPTH));
            check(18'(halfFull), 18'(i + 1 <= DEPTH / 2));
        end
        pinOp(1'b1, 1'b0, 1'b1, 18'h3FFFF);
        check(18'(fullFlagN), 18'h00000);
    endtask

    task automatic testDrain();
        pinOp(1'b0, 1'b1, 1'b1, 18'h00000);
        check(18'(emptyFlagN), 18'h00001);
        outputEnableN <= 1'b1;
        repeat (8) @(posedge mclk);
        check(18'(dataOutEn), 18'h00000);
        outputEnableN <= 1'b0;
        repeat (8) @(posedge mclk);
        check(18'(dataOutEn), 18'h00001);
        for (int i = 0; i < DEPTH; i++) begin
            pinOp(1'b0, 1'b0, 1'b1, 18'h00000);
            check(dataOut, pat(i));
            check(18'(emptyFlagN), 18'(i + 1 < DEPTH));
            check(18'(almostEmptyFlagN), 18'(DEPTH - i - 1 > OFF));
        end
        pinOp(1'b0, 1'b0, 1'b1, 18'h00000);
        check(dataOut, pat(DEPTH - 1));
    endtask

    task automatic testRetransmit();
        flagSyncSelect <= 1'b1;
        doReset();
        check(18'(emptyFlagN), 18'h00000);
        for (int i = 0; i < 3; i++) begin
            pinOp(1'b1, 1'b0, 1'b1, pat(i));
        end
        check(18'({almostEmptyFlagN, almostFullFlagN}), 18'h00003);
        pinOp(1'b0, 1'b1, 1'b1, 18'h00000);
        for (int i = 0; i < 2; i++) begin
            pinOp(1'b0, 1'b0, 1'b1, 18'h00000);
            check(dataOut, pat(i));
        end
        firstLoadRetransmit <= 1'b1;
        repeat (8) @(posedge mclk);
        firstLoadRetransmit <= 1'b0;
        repeat (8) @(posedge mclk);
        pinOp(1'b0, 1'b0, 1'b1, 18'h00000);
        check(dataOut, pat(0));
    endtask

    // One device leading a chain: token handover and expansion pulses
    task automatic testCascade();
        int wBase;
        int rBase;
        cascadeMode <= 1'b1;
        doReset();
        wBase = wxoCnt;
        rBase = rxoCnt;
        for (int i = 0; i < DEPTH; i++) begin
            pinOp(1'b1, 1'b0, 1'b1, pat(i));
        end
        check(18'(wxoCnt - wBase), 18'h00001);
        pinOp(1'b0, 1'b0, 1'b1, 18'h00000);
        check(dataOut, pat(0));
        pinOp(1'b1, 1'b0, 1'b1, 18'h3FFFF);
        check(18'(fullFlagN), 18'h00001);
        writeCascadeIn <= 1'b1;
        repeat (8) @(posedge mclk);
        writeCascadeIn <= 1'b0;
        repeat (8) @(posedge mclk);
        pinOp(1'b1, 1'b0, 1'b1, pat(DEPTH));
        check(18'(fullFlagN), 18'h00000);
        check(18'(wxoCnt - wBase), 18'h00002);
        for (int i = 1; i <= DEPTH; i++) begin
            pinOp(1'b0, 1'b0, 1'b1, 18'h00000);
            check(dataOut, pat(i));
        end
        check(18'(rxoCnt - rBase), 18'h00001);
        check(18'(emptyFlagN), 18'h00000);
    endtask

    initial begin
        doReset();
        testResetState();
        testOffset();
        testFill();
        testDrain();
        testRetransmit();
        testCascade();
        reportAndStop();
    end
endmodule
`default_nettype wire
